//--- bod_decoder_top.sv
// Purpose: byte-op instruction decoder with sequencing and control regs
// Assumes: fetch unit presents one word per fetch_valid cycle
// Notes:   datapath reports skip and branch outcomes two cycles after issue
//
// Contract
// - d clear to accumulator, set to file
// - a clear access bank, set uses bank pointer
// - file ops carry 8-bit address low byte
// - two-word move, 12-bit source then destination
// - bit ops carry 3-bit bit select
// - literal ops take 8-bit immediate low byte
// - jump and call form 20-bit target
// - call first word holds fast bit
// - branch offsets: 11-bit unconditional, 8-bit conditional
// - add and add-carry change all five flags
// - logical group changes zero and negative only
// - subtract group all flags, move-file zero/negative
// - increment/decrement all flags, skip variants none
// - compare-and-skip group changes no flags
// - rotate flag effects by carry use
// - multiply, clear, set, store, negate flags
// - port read-modify-write uses pin levels
// - timer write clears assigned prescaler
// - pc change or true skip adds nop cycle
// - orphan second word runs as nop
// - fast bit saves and restores shadow registers
// - multiply writes 16-bit product bytes
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module bod_decoder_top
  import bod_pkg::*;
#(
  parameter logic [3:0]  ACCESS_BANK = 4'h0,
  parameter logic [11:0] PORT_B_ADDR = 12'h081,
  parameter logic [11:0] TIMER0_ADDR = 12'h056
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // fetch side, then skip and branch outcomes from the datapath
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_word,
  input  wire logic        skip_true,
  input  wire logic        branch_taken,
  // datapath side
  output logic             dec_valid,
  output logic [5:0]       dec_op,
  output logic [4:0]       flag_update,
  output logic             dest_is_file,
  output logic [11:0]      file_addr,
  output logic [11:0]      src_addr,
  output logic [2:0]       bit_sel,
  output logic [7:0]       literal_val,
  output logic [19:0]      jump_target,
  output logic [10:0]      branch_offset,
  output logic             shadow_save,
  output logic             shadow_restore,
  output logic             use_pin_levels,
  output logic             clr_prescaler,
  output logic             product_write,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // state
  bod_state_type state_ff;
  bod_state_type nxt_state;
  bod_ctrl_type  ctrl_ff;
  bod_ctrl_type  nxt_ctrl;
  logic [15:0]   first_ff;      // first word of a two-word pair
  logic [4:0]    ctrl_reg_ff;   // bank pointer and prescaler-assigned
  logic [15:0]   count_ff;
  logic          bvalid_ff;
  logic [1:0]    bresp_ff;
  logic          rvalid_ff;
  logic [31:0]   rdata_ff;
  logic [1:0]    rresp_ff;

  // field decode of the incoming word
  bod_dec_if dif ();
  assign dif.word = fetch_word;
  bod_field_decode u_dec (
    .dif (dif)
  );

  // control register fields
  wire logic [3:0] bank_pointer_reg = ctrl_reg_ff[BOD_CTRL_BANK_LSB +: 4];
  wire logic       psa_assigned     = ctrl_reg_ff[BOD_CTRL_PSA_BIT];

  // sequencing decisions
  wire logic in_exec   = (state_ff == BOD_ST_EXEC);
  wire logic in_word2  = (state_ff == BOD_ST_WORD2);
  wire logic in_flush  = (state_ff == BOD_ST_FLUSH);
  wire logic second_ok = fetch_word[15:12] == BOD_PFX_SECOND;
  wire logic redirect  = skip_true || branch_taken;   // outcome of last issue
  wire logic issue1    = fetch_valid && in_exec && !redirect;
  wire logic start2    = issue1 && dif.two_word;
  wire logic issue2    = fetch_valid && in_word2;
  // bit 9 parts the call (110s) from the jump (1111)
  wire logic first_is_call = first_ff[15:12] == 4'he && !first_ff[9];
  wire logic first_is_mov  = first_ff[15:12] == BOD_PFX_FFMOV;

  // resolved file address: access bank or bank pointer
  wire logic [11:0] banked_addr = fetch_word[8] ?
                                  {bank_pointer_reg, fetch_word[7:0]} :
                                  {ACCESS_BANK, fetch_word[7:0]};

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BOD_ST_EXEC: begin
        if (redirect) nxt_state = BOD_ST_FLUSH;
        if (fetch_valid && redirect) nxt_state = BOD_ST_EXEC;
        else if (start2) nxt_state = BOD_ST_WORD2;
      end
      BOD_ST_WORD2: if (fetch_valid) nxt_state = BOD_ST_EXEC;
      BOD_ST_FLUSH: if (fetch_valid) nxt_state = BOD_ST_EXEC;
      default: nxt_state = BOD_ST_EXEC;
    endcase
  end

  // control bundle; a flushed or orphan word leaves it a nop
  always_comb begin
    nxt_ctrl       = '0;
    nxt_ctrl.op    = BOD_OP_NOP;
    nxt_ctrl.valid = fetch_valid;
    if (issue1 && !dif.two_word) begin
      nxt_ctrl.op        = dif.op;
      nxt_ctrl.flags     = dif.flags;
      nxt_ctrl.dest_file = dif.dest_file;
      nxt_ctrl.file_addr = dif.has_addr ? banked_addr : 12'h000;
      nxt_ctrl.bit_sel   = fetch_word[11:9];
      nxt_ctrl.literal   = fetch_word[7:0];
      nxt_ctrl.offset    = (dif.op == BOD_OP_RJMP) ?
                           fetch_word[10:0] :
                           {{3{fetch_word[7]}}, fetch_word[7:0]};
      nxt_ctrl.shadow_restore = (dif.op == BOD_OP_RET) &&
                                fetch_word[0];
      nxt_ctrl.prod_write = dif.op == BOD_OP_MUL;
      nxt_ctrl.use_pins  = dif.has_addr && dif.writes_file &&
                           banked_addr == PORT_B_ADDR;
      nxt_ctrl.clr_prescaler = dif.writes_file && psa_assigned &&
                               banked_addr == TIMER0_ADDR;
    end else if (issue2 && second_ok) begin
      nxt_ctrl.op = first_is_mov ? BOD_OP_FFMOV :
                    first_is_call ? BOD_OP_CALL : BOD_OP_ABSOLUTE_JUMP_OP;
      nxt_ctrl.src_addr  = first_ff[11:0];
      nxt_ctrl.file_addr = fetch_word[11:0];
      nxt_ctrl.dest_file = first_is_mov;
      nxt_ctrl.target    = {fetch_word[11:0], first_ff[7:0]};
      nxt_ctrl.shadow_save = first_is_call && first_ff[8];
      nxt_ctrl.use_pins  = first_is_mov && fetch_word[11:0] == PORT_B_ADDR &&
                           first_ff[11:0] == PORT_B_ADDR;
      nxt_ctrl.clr_prescaler = first_is_mov && psa_assigned &&
                               fetch_word[11:0] == TIMER0_ADDR;
    end
  end

  // decoder registers; reset parks everything at a nop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= BOD_ST_EXEC;
      ctrl_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      ctrl_ff  <= nxt_ctrl;
    end
  end

  // first word held while its partner is fetched
  always_ff @(posedge clk) begin
    if (sys_rst) first_ff <= 16'h0000;
    else if (start2) first_ff <= fetch_word;
  end

  // count of words passed to the datapath, shown in status
  always_ff @(posedge clk) begin
    if (sys_rst) count_ff <= 16'h0000;
    else if (fetch_valid) count_ff <= count_ff + 16'h0001;
  end

  // datapath outputs straight from the control flops
  assign dec_valid      = ctrl_ff.valid;
  assign dec_op         = ctrl_ff.op;
  assign flag_update    = ctrl_ff.flags;
  assign dest_is_file   = ctrl_ff.dest_file;
  assign file_addr      = ctrl_ff.file_addr;
  assign src_addr       = ctrl_ff.src_addr;
  assign bit_sel        = ctrl_ff.bit_sel;
  assign literal_val    = ctrl_ff.literal;
  assign jump_target    = ctrl_ff.target;
  assign branch_offset  = ctrl_ff.offset;
  assign shadow_save    = ctrl_ff.shadow_save;
  assign shadow_restore = ctrl_ff.shadow_restore;
  assign use_pin_levels = ctrl_ff.use_pins;
  assign clr_prescaler  = ctrl_ff.clr_prescaler;
  assign product_write  = ctrl_ff.prod_write;

  // axi write: address and data taken together, one outstanding
  wire logic wr_take  = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  wire logic wr_ctrl  = wr_take && s_axi_awaddr == BOD_OFS_CTRL;
  wire logic wr_known = (s_axi_awaddr == BOD_OFS_CTRL) ||
                        (s_axi_awaddr == BOD_OFS_STATUS);
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= BOD_RESP_OKAY;
    end else if (wr_take) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_known ? BOD_RESP_OKAY : BOD_RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // control register; only the low byte lane holds bits
  always_ff @(posedge clk) begin
    if (sys_rst) ctrl_reg_ff <= BOD_CTRL_RESET;
    else if (wr_ctrl && s_axi_wstrb[0]) ctrl_reg_ff <= s_axi_wdata[4:0];
  end

  // axi read: one outstanding, data registered with the response
  wire logic rd_take = s_axi_arvalid && !rvalid_ff;
  wire logic [31:0] rd_mux =
    (s_axi_araddr == BOD_OFS_CTRL)   ? {27'h0000000, ctrl_reg_ff} :
    (s_axi_araddr == BOD_OFS_STATUS) ? {13'h0000, state_ff, count_ff} :
                                       32'h00000000;
  assign s_axi_arready = rd_take;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= BOD_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= (s_axi_araddr == BOD_OFS_CTRL ||
                    s_axi_araddr == BOD_OFS_STATUS) ?
                   BOD_RESP_OKAY : BOD_RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // checks next to the logic they guard
  a_reset_gives_nop: assert property (@(posedge clk)
    $past(sys_rst) |-> (dec_op == BOD_OP_NOP && !dec_valid))
    else $error("decoder not at nop after reset");

  a_dest_bit_route: assert property (@(posedge clk) disable iff (sys_rst)
    $past(issue1 && !dif.two_word && dif.has_addr && fetch_word[15:12] != 4'h6
          && dif.op != BOD_OP_MUL && dif.op != BOD_OP_BIT) |->
    dest_is_file == $past(fetch_word[9]))
    else $error("destination bit routed wrongly");

  a_bank_select: assert property (@(posedge clk) disable iff (sys_rst)
    $past(issue1 && dif.has_addr && !fetch_word[8]) |->
    file_addr[11:8] == ACCESS_BANK)
    else $error("access bank not forced");

  a_move_pair: assert property (@(posedge clk) disable iff (sys_rst)
    (issue2 && second_ok && first_is_mov) |=>
    dec_op == BOD_OP_FFMOV && src_addr == $past(first_ff[11:0]))
    else $error("two-word move not assembled");

  a_jump_target: assert property (@(posedge clk) disable iff (sys_rst)
    $past(issue2 && second_ok && !first_is_mov) |->
    jump_target[19:8] == $past(fetch_word[11:0]))
    else $error("jump target high bits wrong");

  a_orphan_nop: assert property (@(posedge clk) disable iff (sys_rst)
    (fetch_valid && in_exec && fetch_word[15:12] == BOD_PFX_SECOND) |=>
    dec_op == BOD_OP_NOP && flag_update == BOD_FLG_NONE)
    else $error("orphan second word not a nop");

  a_skip_flush: assert property (@(posedge clk) disable iff (sys_rst)
    (redirect && fetch_valid && in_exec) |=>
    dec_valid && dec_op == BOD_OP_NOP)
    else $error("redirect did not insert a nop");

  a_flush_drop: assert property (@(posedge clk) disable iff (sys_rst)
    (in_flush && fetch_valid) |=> dec_valid && dec_op == BOD_OP_NOP)
    else $error("word after a lone redirect not dropped");

  a_logic_flags: assert property (@(posedge clk) disable iff (sys_rst)
    (issue1 && fetch_word[15:12] == 4'h1) |=>
    flag_update == BOD_FLG_ZN)
    else $error("logical group flag mask wrong");

  a_mul_product: assert property (@(posedge clk) disable iff (sys_rst)
    product_write |-> (flag_update == BOD_FLG_NONE &&
                       dec_op == BOD_OP_MUL))
    else $error("multiply flags or product strobe wrong");

  a_prescaler_clear: assert property (@(posedge clk) disable iff (sys_rst)
    clr_prescaler |-> $past(psa_assigned) &&
    (file_addr == TIMER0_ADDR))
    else $error("prescaler cleared without cause");

  a_skip_no_flags: assert property (@(posedge clk) disable iff (sys_rst)
    (issue1 && dif.skip_op) |=> flag_update == BOD_FLG_NONE)
    else $error("skip instruction changes flags");

endmodule : bod_decoder_top
`default_nettype wire

//--- bod_pkg.sv
// Purpose: shared constants and types of the byte-op instruction decoder
// Assumes: 16-bit program words, 10 MHz core clock
// Notes:   flag masks are ordered {negative, overflow, zero, digit, carry}
`default_nettype none
package bod_pkg;

  // register offsets on the control bus (byte addresses)
  localparam logic [3:0] BOD_OFS_CTRL   = 4'h0;
  localparam logic [3:0] BOD_OFS_STATUS = 4'h4;
  // control register fields and reset value
  localparam int         BOD_CTRL_BANK_LSB = 0;
  localparam int         BOD_CTRL_PSA_BIT  = 4;
  localparam logic [4:0] BOD_CTRL_RESET    = 5'h00;
  // status register field positions
  localparam int BOD_STAT_CNT_LSB   = 0;
  localparam int BOD_STAT_STATE_LSB = 16;
  // axi responses
  localparam logic [1:0] BOD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] BOD_RESP_DECERR = 2'h3;

  // instruction word prefixes
  localparam logic [3:0] BOD_PFX_SECOND = 4'hf;
  localparam logic [3:0] BOD_PFX_FFMOV  = 4'hc;

  // status flag update masks
  localparam logic [4:0] BOD_FLG_NONE = 5'h00;
  localparam logic [4:0] BOD_FLG_ALL  = 5'h1f;
  localparam logic [4:0] BOD_FLG_ZN   = 5'h14;
  localparam logic [4:0] BOD_FLG_CZN  = 5'h15;
  localparam logic [4:0] BOD_FLG_Z    = 5'h04;

  // decoded operations
  typedef enum logic [5:0] {
    BOD_OP_NOP    = 6'h00, BOD_OP_ADD    = 6'h01, BOD_OP_ADDC   = 6'h02,
    BOD_OP_AND    = 6'h03, BOD_OP_OR     = 6'h04, BOD_OP_XOR    = 6'h05,
    BOD_OP_COM    = 6'h06, BOD_OP_SUBFB  = 6'h07, BOD_OP_SUBB   = 6'h08,
    BOD_OP_SUB    = 6'h09, BOD_OP_FMOV   = 6'h0a, BOD_OP_INC    = 6'h0b,
    BOD_OP_DEC    = 6'h0c, BOD_OP_DECSZ  = 6'h0d, BOD_OP_INCSZ  = 6'h0e,
    BOD_OP_DECSNZ = 6'h0f, BOD_OP_INCSNZ = 6'h10, BOD_OP_CPLT   = 6'h11,
    BOD_OP_CPEQ   = 6'h12, BOD_OP_CPGT   = 6'h13, BOD_OP_TST    = 6'h14,
    BOD_OP_RLC    = 6'h15, BOD_OP_RRC    = 6'h16, BOD_OP_RL     = 6'h17,
    BOD_OP_RR     = 6'h18, BOD_OP_SWAP   = 6'h19, BOD_OP_MUL    = 6'h1a,
    BOD_OP_CLR    = 6'h1b, BOD_OP_SET    = 6'h1c, BOD_OP_NEG    = 6'h1d,
    BOD_OP_STORE  = 6'h1e, BOD_OP_FFMOV  = 6'h1f, BOD_OP_ABSOLUTE_JUMP_OP   = 6'h20,
    BOD_OP_CALL   = 6'h21, BOD_OP_RJMP   = 6'h22, BOD_OP_BCOND  = 6'h23,
    BOD_OP_RET    = 6'h24, BOD_OP_BIT    = 6'h25, BOD_OP_LIT    = 6'h26
  } bod_op_type;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    BOD_ST_EXEC  = 3'b001,
    BOD_ST_WORD2 = 3'b010,
    BOD_ST_FLUSH = 3'b100
  } bod_state_type;

  // registered control bundle sent to the datapath
  typedef struct packed {
    logic        valid;
    bod_op_type  op;
    logic [4:0]  flags;
    logic        dest_file;
    logic [11:0] file_addr;
    logic [11:0] src_addr;
    logic [2:0]  bit_sel;
    logic [7:0]  literal;
    logic [19:0] target;
    logic [10:0] offset;
    logic        shadow_save;
    logic        shadow_restore;
    logic        use_pins;
    logic        clr_prescaler;
    logic        prod_write;
  } bod_ctrl_type;

endpackage : bod_pkg
`default_nettype wire

//--- bod_dec_if.sv
// Purpose: carries one program word and its field decode
// Assumes: purely combinational path between decoder and sequencer
// Notes:   none
`timescale 1ns/100ps
`default_nettype none
interface bod_dec_if;
  import bod_pkg::*;
  logic [15:0] word;
  bod_op_type  op;
  logic [4:0]  flags;
  logic        dest_file;
  logic        writes_file;
  logic        two_word;
  logic        pc_change;
  logic        skip_op;
  logic        has_addr;

  modport dec (input word, output op, flags, dest_file, writes_file,
               output two_word, pc_change, skip_op, has_addr);
  modport use_side (output word, input op, flags, dest_file, writes_file,
                    input two_word, pc_change, skip_op, has_addr);
endinterface : bod_dec_if
`default_nettype wire

//--- bod_field_decode.sv
// Purpose: maps one program word to an operation and its flag effects
// Assumes: word is stable for the cycle it is decoded in
// Notes:   a word starting with the second-word prefix decodes as no-op
`timescale 1ns/100ps
`default_nettype none
module bod_field_decode
  import bod_pkg::*;
(
  bod_dec_if.dec dif
);

  // opcode table
  function automatic bod_op_type op_of(input logic [15:0] w);
    logic [3:0] hi;
    logic [3:0] m;
    hi = w[15:12];
    m  = w[11:8];
    op_of = BOD_OP_NOP;
    case (hi)
      4'h0: begin
        if (m[3] || m == 4'h1) op_of = BOD_OP_LIT;
        else if (m[3:1] == 3'b001) op_of = BOD_OP_MUL;
        else if (m[3:2] == 2'b01) op_of = BOD_OP_DEC;
        else if (w[11:1] == 11'h009) op_of = BOD_OP_RET;
      end
      4'h1: op_of = (m[3:2] == 2'b00) ? BOD_OP_OR :
                    (m[3:2] == 2'b01) ? BOD_OP_AND :
                    (m[3:2] == 2'b10) ? BOD_OP_XOR : BOD_OP_COM;
      4'h2: op_of = (m[3:2] == 2'b00) ? BOD_OP_ADDC :
                    (m[3:2] == 2'b01) ? BOD_OP_ADD :
                    (m[3:2] == 2'b10) ? BOD_OP_INC : BOD_OP_DECSZ;
      4'h3: op_of = (m[3:2] == 2'b00) ? BOD_OP_RRC :
                    (m[3:2] == 2'b01) ? BOD_OP_RLC :
                    (m[3:2] == 2'b10) ? BOD_OP_SWAP : BOD_OP_INCSZ;
      4'h4: op_of = (m[3:2] == 2'b00) ? BOD_OP_RR :
                    (m[3:2] == 2'b01) ? BOD_OP_RL :
                    (m[3:2] == 2'b10) ? BOD_OP_INCSNZ : BOD_OP_DECSNZ;
      4'h5: op_of = (m[3:2] == 2'b00) ? BOD_OP_FMOV :
                    (m[3:2] == 2'b01) ? BOD_OP_SUBFB :
                    (m[3:2] == 2'b10) ? BOD_OP_SUBB : BOD_OP_SUB;
      4'h6: begin
        case (m[3:1])
          3'b000:  op_of = BOD_OP_CPLT;
          3'b001:  op_of = BOD_OP_CPEQ;
          3'b010:  op_of = BOD_OP_CPGT;
          3'b011:  op_of = BOD_OP_TST;
          3'b100:  op_of = BOD_OP_SET;
          3'b101:  op_of = BOD_OP_CLR;
          3'b110:  op_of = BOD_OP_NEG;
          default: op_of = BOD_OP_STORE;
        endcase
      end
      4'h7, 4'h8, 4'h9, 4'ha, 4'hb: op_of = BOD_OP_BIT;
      4'hc: op_of = BOD_OP_FFMOV;
      4'hd: op_of = BOD_OP_RJMP;
      4'he: begin
        if (!m[3]) op_of = BOD_OP_BCOND;
        else if (m[3:1] == 3'b110) op_of = BOD_OP_CALL;
        else if (m == 4'hf) op_of = BOD_OP_ABSOLUTE_JUMP_OP;
      end
      default: op_of = BOD_OP_NOP;
    endcase
  endfunction : op_of

  // status flags each operation may change
  function automatic logic [4:0] flags_of(input bod_op_type op);
    case (op)
      BOD_OP_ADD, BOD_OP_ADDC, BOD_OP_SUB, BOD_OP_SUBB, BOD_OP_SUBFB,
      BOD_OP_INC, BOD_OP_DEC, BOD_OP_NEG:            flags_of = BOD_FLG_ALL;
      BOD_OP_AND, BOD_OP_OR, BOD_OP_XOR, BOD_OP_COM,
      BOD_OP_FMOV, BOD_OP_RL, BOD_OP_RR:             flags_of = BOD_FLG_ZN;
      BOD_OP_RLC, BOD_OP_RRC:                        flags_of = BOD_FLG_CZN;
      BOD_OP_CLR:                                    flags_of = BOD_FLG_Z;
      default:                                       flags_of = BOD_FLG_NONE;
    endcase
  endfunction : flags_of

  // field decode; d bit only exists on the d-carrying byte ops
  wire bod_op_type op_w   = op_of(dif.word);
  wire             has_d  = (dif.word[15:12] != 4'h6) && (op_w != BOD_OP_MUL);
  wire             byte_w = (op_w >= BOD_OP_ADD) && (op_w <= BOD_OP_STORE);
  wire             fix_wr = (op_w == BOD_OP_CLR) || (op_w == BOD_OP_SET) ||
                            (op_w == BOD_OP_NEG) || (op_w == BOD_OP_STORE);

  assign dif.op          = op_w;
  assign dif.flags       = flags_of(op_w);
  assign dif.dest_file   = byte_w && has_d && dif.word[9];
  assign dif.writes_file = (byte_w && has_d && dif.word[9]) || fix_wr;
  assign dif.two_word    = (op_w == BOD_OP_FFMOV) || (op_w == BOD_OP_CALL) ||
                           (op_w == BOD_OP_ABSOLUTE_JUMP_OP);
  assign dif.pc_change   = (op_w == BOD_OP_RJMP) || (op_w == BOD_OP_RET);
  assign dif.skip_op     = ((op_w >= BOD_OP_DECSZ) && (op_w <= BOD_OP_TST))
                           || (op_w == BOD_OP_BIT);
  assign dif.has_addr    = byte_w || (op_w == BOD_OP_BIT);

endmodule : bod_field_decode
`default_nettype wire

//--- bod_dp_model.sv
// Purpose: datapath stand-in reporting skip and branch outcomes
// Assumes: outcome comes one cycle after the decoded word
// Notes:   skips only when told, so the bench picks the test result
`timescale 1ns/100ps
`default_nettype none
module bod_dp_model
  import bod_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       skip_en,
  input  wire logic       dec_valid,
  input  wire logic [5:0] dec_op,
  output logic            skip_true,
  output logic            branch_taken
);
  // a true skip or a taken branch turns the next word into a nop
  always_ff @(posedge clk) begin
    skip_true    <= !sys_rst && dec_valid && skip_en &&
                    dec_op == BOD_OP_DECSZ;
    branch_taken <= !sys_rst && dec_valid && dec_op == BOD_OP_RJMP;
  end
endmodule : bod_dp_model
`default_nettype wire

//--- test_byte_op_instruction_decoder.sv
// Purpose: self-checking bench for the byte-op instruction decoder
// Assumes: default top parameters, access bank 0
// Notes:   a gap cycle between words keeps every drive on its own edge
`timescale 1ns/100ps
`default_nettype none
module test_byte_op_instruction_decoder import bod_pkg::*;
;
  logic        clk, sys_rst, fetch_valid, skip_en, skip_true, branch_taken;
  logic        dec_valid, dest_is_file, shadow_save, shadow_restore;
  logic        use_pin_levels, clr_prescaler, product_write;
  logic [15:0] fetch_word;
  logic [5:0]  dec_op;
  logic [4:0]  flag_update;
  logic [11:0] file_addr, src_addr;
  logic [2:0]  bit_sel;
  logic [7:0]  literal_val;
  logic [19:0] jump_target;
  logic [10:0] branch_offset;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          failures = 0, checks_done = 0;
  // byte-oriented codes, the twelve with a d bit first
  logic [15:0] tw [16] = '{16'h2612, 16'h2012, 16'h1412, 16'h1812, 16'h1c12,
    16'h5a12, 16'h5281, 16'h2812, 16'h4812, 16'h3012, 16'h4412, 16'h3812,
    16'h6412, 16'h0212, 16'h6a12, 16'h6c12};
  bod_op_type top [16] = '{BOD_OP_ADD, BOD_OP_ADDC, BOD_OP_AND, BOD_OP_XOR,
    BOD_OP_COM, BOD_OP_SUBB, BOD_OP_FMOV, BOD_OP_INC, BOD_OP_INCSNZ,
    BOD_OP_RRC, BOD_OP_RL, BOD_OP_SWAP, BOD_OP_CPGT, BOD_OP_MUL, BOD_OP_CLR,
    BOD_OP_NEG};
  logic [4:0] tf [16] = '{5'h1f, 5'h1f, 5'h14, 5'h14, 5'h14, 5'h1f, 5'h14,
    5'h1f, 5'h00, 5'h15, 5'h14, 5'h00, 5'h00, 5'h00, 5'h04, 5'h1f};
  bod_decoder_top DUT (.clk, .sys_rst, .fetch_valid, .fetch_word, .skip_true,
    .branch_taken, .dec_valid, .dec_op, .flag_update, .dest_is_file,
    .file_addr, .src_addr, .bit_sel, .literal_val, .jump_target,
    .branch_offset, .shadow_save, .shadow_restore, .use_pin_levels,
    .clr_prescaler, .product_write, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  bod_dp_model PTR (.clk, .sys_rst, .skip_en, .dec_valid, .dec_op, .skip_true,
    .branch_taken);
  // compare, count, report
  task chk(input logic [39:0] g, input logic [39:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // one word in, decoded fields read after the answering edge
  task fetch(input logic [15:0] w);
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_word  <= w;
    @(posedge clk);
    fetch_valid <= 1'b0;
    #1;
  endtask : fetch
  task axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(posedge clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [3:0] a);
    @(posedge clk);
    {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    {rs, rd} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task give_verdict;
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard, far beyond the roughly 90 cycles the tests need
  initial begin
    #200us;
    failures++;
    give_verdict;
  end
  initial begin
    {sys_rst, skip_en, fetch_valid, s_axi_awvalid, s_axi_wvalid} = 5'h18;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 7'h0f;
    {fetch_word, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk({dec_valid, dec_op}, {1'b0, BOD_OP_NOP});
    axi_rd(BOD_OFS_CTRL);
    chk(rd, BOD_CTRL_RESET);
    for (int i = 0; i < 16; i++) begin
      fetch(tw[i]);
      chk({dec_valid, dec_op, flag_update},
        {1'b1, top[i], tf[i]});
      chk(file_addr, {4'h0, tw[i][7:0]});
      chk({use_pin_levels, product_write},
        {tw[i] == 16'h5281, top[i] == BOD_OP_MUL});
      if (i < 12)
        chk(dest_is_file, tw[i][9]);
    end
    // bank 5 with the prescaler assigned, then a bad address
    axi_wr(BOD_OFS_CTRL, 32'h15);
    chk(rs, BOD_RESP_OKAY);
    axi_rd(BOD_OFS_CTRL);
    chk({rs, rd}, {BOD_RESP_OKAY, 32'h15});
    axi_rd(4'h8);
    chk({rs, rd}, {BOD_RESP_DECERR, 32'h0});
    fetch(16'h2712);
    chk(file_addr, 12'h512);
    fetch(16'h6e56);
    chk(clr_prescaler, 1'b1);
    fetch(16'hc123);
    chk(dec_op, BOD_OP_NOP);
    fetch(16'hf456);
    chk({dec_op, src_addr, file_addr}, {BOD_OP_FFMOV, 24'h123456});
    fetch(16'hf000);
    chk(dec_op, BOD_OP_NOP);
    fetch(16'hef34);
    fetch(16'hf567);
    chk({dec_op, jump_target}, {BOD_OP_ABSOLUTE_JUMP_OP, 20'h56734});
    fetch(16'hed78);
    fetch(16'hf000);
    chk({dec_op, shadow_save}, {BOD_OP_CALL, 1'b1});
    fetch(16'h9a12);
    chk(bit_sel, 3'h5);
    fetch(16'h0e7f);
    chk(literal_val, 8'h7f);
    fetch(16'h0013);
    chk({dec_op, shadow_restore}, {BOD_OP_RET, 1'b1});
    fetch(16'he2f0);
    chk({dec_op, branch_offset}, {BOD_OP_BCOND, 11'h7f0});
    // true skip voids the word behind it
    fetch(16'h2c12);
    fetch(16'h2612);
    chk(dec_op, BOD_OP_NOP);
    // redirect in an idle cycle drops the next word that arrives; a taken branch voids the word behind it
    fetch(16'h2c12);
    @(posedge clk);
    fetch(16'h2612);
    chk(dec_op, BOD_OP_NOP);
    fetch(16'hd405);
    chk({dec_op, branch_offset}, {BOD_OP_RJMP, 11'h405});
    fetch(16'h2612);
    chk(dec_op, BOD_OP_NOP);
    give_verdict;
  end
endmodule : test_byte_op_instruction_decoder
`default_nettype wire
